// file: sopm_regs.vh
// Register map, field positions, reset values and timing figures of the special output port mux.
// Assumes a 125 MHz core clock and 32-bit APB data with one register per aligned word.
`ifndef SOPM_REGS_VH
`define SOPM_REGS_VH

// Register byte offsets
`define SOPM_CTRL_OFS 12'h000
`define SOPM_BUZZ_OFS 12'h004
`define SOPM_PORT_OFS 12'h008
`define SOPM_STAT_OFS 12'h00C

// Control register fields
`define SOPM_CTRL_SYNC_EN 0
`define SOPM_CTRL_ALT_EN 1
`define SOPM_CTRL_DUTY 2
`define SOPM_CTRL_DUTY8 3
`define SOPM_CTRL_TCLK_EN 4
`define SOPM_CTRL_DIV_EN 5
`define SOPM_CTRL_SEL_LO 6
`define SOPM_CTRL_SEL_HI 8
`define SOPM_CTRL_HOSC_ON 9
`define SOPM_CTRL_W 10
`define SOPM_CTRL_RST 10'h000

// Buzzer register fields
`define SOPM_BUZZ_ON 0
`define SOPM_BUZZ_SHOT 1
`define SOPM_BUZZ_STOP 2

// Port data register fields: 25, 26, 27, 34, 50, 51
`define SOPM_PORT_W 6
`define SOPM_PORT_P25 0
`define SOPM_PORT_P26 1
`define SOPM_PORT_P27 2
`define SOPM_PORT_P34 3
`define SOPM_PORT_P50 4
`define SOPM_PORT_P51 5
`define SOPM_PORT_RST 6'h2F

// Status register fields
`define SOPM_STAT_PINS_LO 0
`define SOPM_STAT_MAP 6
`define SOPM_STAT_BUSY 7
`define SOPM_STAT_TCLK 8

// Low-speed divider taps (counter bit that toggles at the wanted rate)
`define SOPM_LCD_CNT_W 10
`define SOPM_SYNC_TAP32 3
`define SOPM_SYNC_TAP16 4
`define SOPM_ALT_TAP16 9
`define SOPM_ALT_TAP8 8

// One-shot buzzer duration
`define SOPM_CLK_MHZ 125
`define SOPM_ONESHOT_NS 31250000
`define SOPM_ONESHOT_CYC ((`SOPM_ONESHOT_NS / 1000) * `SOPM_CLK_MHZ)

`endif

// file: sopm_osc_div.v
// Oscillator front end: synchroniser, rising-edge tick and binary divide by 2, 4 and 8.
// Assumes the oscillator pin is asynchronous to CORE_CLK and well below half its rate.
module sopm_osc_div
(
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Oscillator pin and gate
    input wire osc_in,
    input wire run,
    // Divided outputs
    output wire tick,
    output wire [3:0] taps
);

    // Two-stage synchroniser and the delayed copy for edge detection
    reg sync1_q;
    reg sync2_q;
    reg prev_q;
    // Synchronous binary counter of rising edges
    reg [2:0] cnt_q;

    // Synchronise; first stage feeds only the second
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= osc_in;
            sync2_q <= sync1_q & run;
            prev_q <= sync2_q;
        end
    end

    assign tick = sync2_q & ~prev_q;

    // Count edges; a stopped oscillator leaves every tap low
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 3'h0;
        else if (!run)
            cnt_q <= 3'h0;
        else if (tick)
            cnt_q <= cnt_q + 3'h1;
    end

    // Tap 0 is the oscillator itself, taps 1..3 divide by 2, 4, 8
    assign taps = {cnt_q, sync2_q};

endmodule // sopm_osc_div

// file: sopm_lcd_timing.v
// LCD line-sync and alternation generator driven by low-speed oscillator ticks.
// Assumes the low-speed oscillator runs at 32768 Hz, so taps give 2048/1024 Hz and 64/32 Hz.
`include "sopm_regs.vh"
module sopm_lcd_timing
(
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Low-speed tick and duty selection
    input wire tick,
    input wire duty16,
    input wire duty8,
    // Generated waves
    output wire line_sync,
    output wire alt_sig
);

    // Free-running prescaler of low-speed edges
    reg [`SOPM_LCD_CNT_W-1:0] cnt_q;

    // Advance once per oscillator edge
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= {`SOPM_LCD_CNT_W{1'b0}};
        else if (tick)
            cnt_q <= cnt_q + {{(`SOPM_LCD_CNT_W-1){1'b0}}, 1'b1};
    end

    // 1/32 gives 2048 Hz, 1/16 and 1/8 give 1024 Hz
    assign line_sync = (duty16 | duty8) ? cnt_q[`SOPM_SYNC_TAP16] : cnt_q[`SOPM_SYNC_TAP32];
    // 1/8 gives 64 Hz, otherwise 32 Hz
    assign alt_sig = duty8 ? cnt_q[`SOPM_ALT_TAP8] : cnt_q[`SOPM_ALT_TAP16];

endmodule // sopm_lcd_timing

// file: sopm_top.v
// Special output port mux: APB registers, special signal sources and the six port pins.
// Assumes oscillator pins are asynchronous, timer underflow and buzzer wave are on CORE_CLK,
// and the mapping strap is steady when RST_B is released.
//
// How it works
// - Sync 2048/1024 Hz, alternation 32/64 Hz by duty
// - Enables ungated, glitch at most half cycle
// - Timer clock on pin 27, else HIGH
// - Timer clock toggles per underflow
// - Divided clock on pin 34, else HIGH
// - Three-bit select: low/high osc divided 1-8
// - High-speed oscillator off after reset
// - Buzzer on pin 50 by on/shot, stop lowers
// - Second mapping: pin 26 inverted timer clock
// - Pin 26 data ignored in second mapping
// - Second mapping: pin 51 inverted buzzer, idle HIGH
// - Pin 51 data ignored in second mapping
// - Line sync on pin 25, else HIGH
// - First mapping: alternation on pin 26, else HIGH
// - Duty bit picks 1/16 set, 1/32 clear
//
// Registers, one word each, unused bits read zero:
// 0x000 control: 0 sync on, 1 alternation on,
//   2 duty 1/16, 3 duty 1/8 (beats bit 2),
//   4 timer clock on, 5 divided clock on,
//   8:6 divided clock select, 9 fast oscillator on
// 0x004 buzzer: 0 buzzer on, 1 fire one-shot
//   (reads busy), 2 stop one-shot (reads zero)
// 0x008 data bits for pins 25, 26, 27, 34, 50, 51
// 0x00C status: 5:0 pin levels, 6 mapping,
//   7 one-shot busy, 8 timer clock phase
// Other addresses answer with PSLVERR, no effect.
//
// Every transfer takes two cycles: PREADY rises
// in the first access cycle; a write lands at the
// edge that ends it and pins follow a cycle later; a one-shot stop clears the buzzer pins at that same edge.
//
// Out of reset pins 25, 26, 27, 34 and 51 sit
// high and 50 low; the fast oscillator is off and
// the strap is taken on the third edge after release.
//
// Enables gate running waves with no resync, so a
// switch may clip half a cycle. Taps sample the
// oscillators on CORE_CLK, so each edge may land
// up to one core cycle late.
//
// The APB register port and the register offsets were chosen for this implementation.
`include "sopm_regs.vh"
module sopm_top
#(
    parameter ONESHOT_CYC = `SOPM_ONESHOT_CYC
)
(
    // Clock and reset
    input wire CORE_CLK,
    input wire RST_B,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // Signal sources
    input wire LOSC_IN,
    input wire HOSC_IN,
    input wire TMR_UNDERFLOW,
    input wire BUZZER_WAVE_IN,
    input wire MAP_SEL,
    // Oscillator control
    output reg HOSC_EN,
    // Port pins
    output reg PORT_PIN_25,
    output reg PORT_PIN_26,
    output reg PORT_PIN_27,
    output reg PORT_PIN_34,
    output reg PORT_PIN_50,
    output reg PORT_PIN_51
);

    // Software registers
    // (control, data, buzzer on, one-shot state)
    reg [`SOPM_CTRL_W-1:0] ctrl_q;
    reg [`SOPM_PORT_W-1:0] port_q;
    reg buzzer_on_q;
    reg shot_busy_q;
    reg [31:0] shot_cnt_q;
    // Special sources
    reg timer_clock_out_q;
    reg map_q;
    reg map_taken_q;
    // Settling count before the strap is taken
    reg [1:0] map_wait_q;
    // Mapping strap synchroniser
    reg map_s1_q;
    reg map_s2_q;
    // Oscillator and LCD wires; the fast tick is unused
    wire losc_tick;
    wire [3:0] losc_taps;
    wire [3:0] hosc_taps;
    wire lcd_line_sync;
    wire lcd_alternation_sig;
    // Decoded control fields, named after what they switch
    wire lcd_sync_out_enable = ctrl_q[`SOPM_CTRL_SYNC_EN];
    wire lcd_alt_out_enable = ctrl_q[`SOPM_CTRL_ALT_EN];
    wire lcd_drive_duty = ctrl_q[`SOPM_CTRL_DUTY];
    wire timer_clk_out_enable = ctrl_q[`SOPM_CTRL_TCLK_EN];
    wire divclk_out_enable = ctrl_q[`SOPM_CTRL_DIV_EN];
    wire [2:0] divclk_sel = ctrl_q[`SOPM_CTRL_SEL_HI:`SOPM_CTRL_SEL_LO];
    wire high_speed_oscillator = ctrl_q[`SOPM_CTRL_HOSC_ON];
    // Bus strobes: PREADY low keeps a held setup from
    // being answered twice; writes commit only at the
    // edge where the master samples PREADY high
    wire setup = PSEL & ~PENABLE & ~PREADY;
    wire wr = PSEL & PENABLE & PREADY & PWRITE;
    wire hit_ctrl = (PADDR == `SOPM_CTRL_OFS);
    wire hit_buzz = (PADDR == `SOPM_BUZZ_OFS);
    wire hit_port = (PADDR == `SOPM_PORT_OFS);
    wire hit_stat = (PADDR == `SOPM_STAT_OFS);
    wire wr_buzz = wr & hit_buzz;
    wire shot_trig = wr_buzz & PWDATA[`SOPM_BUZZ_SHOT];
    wire shot_stop = wr_buzz & PWDATA[`SOPM_BUZZ_STOP];
    // Selected divided clock and buzzer gating
    // A stop write silences the pins in its own cycle
    wire divided_osc_out;
    wire buzzer_active = (buzzer_on_q | shot_busy_q) & ~shot_stop;

    // Divided clock mux: codes 0-3 low-speed, 4-7 high-speed
    // Bit 2 picks the oscillator, bits 1:0 the tap;
    // every tap of a stopped oscillator reads low
    function mux_div;
        input [2:0] sel;
        input [3:0] lo;
        input [3:0] hi;
        begin
            mux_div = sel[2] ? hi[sel[1:0]] : lo[sel[1:0]];
        end
    endfunction

    assign divided_osc_out = mux_div(divclk_sel, losc_taps, hosc_taps);

    // Low-speed oscillator divider
    // Always running, it also paces the LCD timing
    sopm_osc_div u_losc
    (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .osc_in(LOSC_IN),
        .run(1'b1),
        .tick(losc_tick),
        .taps(losc_taps)
    );

    // High-speed oscillator divider, idle while the oscillator is off
    sopm_osc_div u_hosc
    (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .osc_in(HOSC_IN),
        .run(high_speed_oscillator),
        .tick(),
        .taps(hosc_taps)
    );

    // LCD line-sync and alternation generator
    // Low-speed ticks set both rates
    sopm_lcd_timing u_lcd
    (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .tick(losc_tick),
        .duty16(lcd_drive_duty),
        .duty8(ctrl_q[`SOPM_CTRL_DUTY8]),
        .line_sync(lcd_line_sync),
        .alt_sig(lcd_alternation_sig)
    );

    // Mapping strap: synchronised, then frozen once after reset release
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            map_s1_q <= 1'b0;
            map_s2_q <= 1'b0;
            map_q <= 1'b0;
            map_taken_q <= 1'b0;
            map_wait_q <= 2'h0;
        end
        else
        begin
            map_s1_q <= MAP_SEL;
            map_s2_q <= map_s1_q;
            // Later strap changes are ignored on purpose
            if (!map_taken_q)
            begin
                // Wait until the strap has passed both stages,
                // or the reset level of the chain would be taken
                map_wait_q <= map_wait_q + 2'h1;
                if (map_wait_q == 2'h2)
                begin
                    map_q <= map_s2_q;
                    map_taken_q <= 1'b1;
                end
            end
        end
    end

    // Control and port data registers
    // Written only when the access phase completes, so
    // an abandoned setup leaves them unchanged
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl_q <= `SOPM_CTRL_RST;
            port_q <= `SOPM_PORT_RST;
            buzzer_on_q <= 1'b0;
        end
        else if (wr)
        begin
            if (hit_ctrl)
                ctrl_q <= PWDATA[`SOPM_CTRL_W-1:0];
            if (hit_port)
                port_q <= PWDATA[`SOPM_PORT_W-1:0];
            if (hit_buzz)
                buzzer_on_q <= PWDATA[`SOPM_BUZZ_ON];
        end
    end

    // One-shot buzzer: trigger starts, stop or timeout ends; a trigger beats a clear
    // The burst length is a parameter so a bench can
    // shorten it; the counter holds any 32-bit value
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            shot_busy_q <= 1'b0;
            shot_cnt_q <= 32'h0000_0000;
        end
        else if (shot_trig)
        begin
            shot_busy_q <= 1'b1;
            shot_cnt_q <= ONESHOT_CYC[31:0];
        end
        else if (shot_stop)
            shot_busy_q <= 1'b0;
        else if (shot_busy_q)
        begin
            // Count down the burst length
            if (shot_cnt_q <= 32'h0000_0001)
                shot_busy_q <= 1'b0;
            shot_cnt_q <= shot_cnt_q - 32'h0000_0001;
        end
    end

    // Timer clock halves the underflow rate
    // Underflow is a one-cycle pulse on CORE_CLK, so
    // it needs no synchroniser; the phase resets low
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
            timer_clock_out_q <= 1'b0;
        else if (TMR_UNDERFLOW)
            timer_clock_out_q <= ~timer_clock_out_q;
    end

    // Pin drivers; enables gate the running waves directly, so a switch may clip a half cycle
    // Every pin is a flop so decode never glitches
    // a pin; the price is one cycle of latency
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            PORT_PIN_25 <= 1'b1;
            PORT_PIN_26 <= 1'b1;
            PORT_PIN_27 <= 1'b1;
            PORT_PIN_34 <= 1'b1;
            PORT_PIN_50 <= 1'b0;
            PORT_PIN_51 <= 1'b1;
            HOSC_EN <= 1'b0;
        end
        else
        begin
            HOSC_EN <= high_speed_oscillator;
            // Data bit must be held 1 by software for the wave to show
            PORT_PIN_25 <= port_q[`SOPM_PORT_P25] & (lcd_sync_out_enable ? lcd_line_sync : 1'b1);
            PORT_PIN_27 <= port_q[`SOPM_PORT_P27] & (timer_clk_out_enable ? timer_clock_out_q : 1'b1);
            PORT_PIN_34 <= port_q[`SOPM_PORT_P34] & (divclk_out_enable ? divided_osc_out : 1'b1);
            // Data bit must be held 0 by software for the buzzer to show
            PORT_PIN_50 <= port_q[`SOPM_PORT_P50] | (buzzer_active & BUZZER_WAVE_IN);
            if (map_q)
            begin
                // Second mapping: inverted copies, data bits ignored
                PORT_PIN_26 <= timer_clk_out_enable & ~timer_clock_out_q;
                PORT_PIN_51 <= ~(buzzer_active & BUZZER_WAVE_IN);
            end
            else
            begin
                PORT_PIN_26 <= port_q[`SOPM_PORT_P26] & (lcd_alt_out_enable ? lcd_alternation_sig : 1'b1);
                PORT_PIN_51 <= port_q[`SOPM_PORT_P51];
            end
        end
    end

    // APB slave: answer in the first access cycle, error on unmapped address
    // Read data is caught at setup and held until the
    // next read, so a slow master still sees it
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end
        else
        begin
            PREADY <= setup;
            PSLVERR <= setup & ~(hit_ctrl | hit_buzz | hit_port | hit_stat);
            if (setup & ~PWRITE)
            begin
                PRDATA <= 32'h0000_0000;
                if (hit_ctrl)
                    PRDATA[`SOPM_CTRL_W-1:0] <= ctrl_q;
                else if (hit_buzz)
                    PRDATA[`SOPM_BUZZ_SHOT:0] <= {shot_busy_q, buzzer_on_q};
                else if (hit_port)
                    PRDATA[`SOPM_PORT_W-1:0] <= port_q;
                else if (hit_stat)
                    // Live pin levels, mapping, one-shot busy, timer clock phase
                    PRDATA[`SOPM_STAT_TCLK:0] <= {timer_clock_out_q, shot_busy_q, map_q,
                        PORT_PIN_51, PORT_PIN_50, PORT_PIN_34, PORT_PIN_27, PORT_PIN_26, PORT_PIN_25};
            end
        end
    end

endmodule // sopm_top

// file: sopm_osc_model.sv
// Crystal models driving the low- and high-speed oscillator pins of the mux.
// Assumes an 8 ns core clock; periods are whole core cycles so divided rates measure exactly.
module sopm_osc_model
#(
    parameter int LP = 80,
    parameter int HP = 48
)
(
    // Oscillator control from the device
    input wire logic hosc_en,
    // Oscillator pins
    output logic losc,
    output logic hosc
);
    timeunit 1ns;
    timeprecision 1ps;

    // Low-speed crystal runs free, offset so no edge lands on a core edge
    initial
    begin
        losc = 1'h0;
        #3;
        forever #(LP / 2) losc = ~losc;
    end

    // High-speed crystal swings only while switched on, held low when off
    initial
    begin
        hosc = 1'h0;
        #5;
        forever
        begin
            #(HP / 2);
            hosc = hosc_en ? ~hosc : 1'h0;
        end
    end
endmodule // sopm_osc_model

// file: sopm_chk.sv
// Checker for the mux: bus answer, reset pin levels and second-mapping pin pairs.
// Assumes the mapping strap moves only while reset is held.
module sopm_chk
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Sources and pins
    input wire logic TMR_UNDERFLOW,
    input wire logic BUZZER_WAVE_IN,
    input wire logic MAP_SEL,
    input wire logic HOSC_EN,
    input wire logic PORT_PIN_25,
    input wire logic PORT_PIN_26,
    input wire logic PORT_PIN_27,
    input wire logic PORT_PIN_34,
    input wire logic PORT_PIN_50,
    input wire logic PORT_PIN_51
);
    logic [3:0] up_q; // Cycles since reset, saturating
    logic m1; // Second mapping, strap settled
    logic su; // Write accepted this cycle
    assign m1 = MAP_SEL && (up_q == 4'hF);
    assign su = PSEL && PENABLE && PREADY && PWRITE;

    // Count past the strap capture so pin checks skip its settling
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
            up_q <= 4'h0;
        else if (up_q != 4'hF)
            up_q <= up_q + 4'h1;
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    a_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no answer after setup");
    a_ready_once: assert property (PREADY |=> !PREADY)
        else $error("answer longer than one cycle");
    a_err_range: assert property (PREADY && PADDR > 12'h00C |-> PSLVERR)
        else $error("unmapped access not refused");
    a_ok_range: assert property (PREADY && PADDR <= 12'h00C && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("mapped access refused");
    a_reset_pins: assert property ($rose(RST_B) |-> PORT_PIN_25 && PORT_PIN_26 && PORT_PIN_27 &&
        PORT_PIN_34 && !PORT_PIN_50 && PORT_PIN_51 && !HOSC_EN)
        else $error("pin levels wrong out of reset");
    a_tclk_apart: assert property (m1 |-> !(PORT_PIN_26 && PORT_PIN_27))
        else $error("timer clock pins both high");
    a_tclk_cause: assert property (m1 && $changed(PORT_PIN_26) |-> $past(TMR_UNDERFLOW, 2) || $past(su, 2))
        else $error("inverted timer clock moved without cause");
    a_buzz_inv: assert property (m1 |-> PORT_PIN_50 || PORT_PIN_51)
        else $error("buzzer pins both low");
    a_buzz_wave: assert property (m1 && !PORT_PIN_51 |-> $past(BUZZER_WAVE_IN))
        else $error("inverted buzzer low without wave");
endmodule // sopm_chk

bind sopm_top sopm_chk chk_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .TMR_UNDERFLOW(TMR_UNDERFLOW),
    .BUZZER_WAVE_IN(BUZZER_WAVE_IN), .MAP_SEL(MAP_SEL), .HOSC_EN(HOSC_EN), .PORT_PIN_25(PORT_PIN_25),
    .PORT_PIN_26(PORT_PIN_26), .PORT_PIN_27(PORT_PIN_27), .PORT_PIN_34(PORT_PIN_34),
    .PORT_PIN_50(PORT_PIN_50), .PORT_PIN_51(PORT_PIN_51));

// file: sopm_tb.sv
// Self-checking bench for the mux: registers, wave rates, timer clock, buzzer, both mappings.
// Assumes an 8 ns core clock and the crystal models of sopm_osc_model.
`include "sopm_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LP = 10; // Low-speed period in core cycles
    localparam int HP = 6; // High-speed period in core cycles
    localparam int SHOT = 20; // Shortened one-shot length
    logic CORE_CLK = 1'h0;
    logic RST_B = 1'h0;
    logic PSEL = 1'h0;
    logic PENABLE = 1'h0;
    logic PWRITE = 1'h0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic TMR_UNDERFLOW = 1'h0;
    logic BUZZER_WAVE_IN = 1'h0;
    logic MAP_SEL = 1'h0;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, HOSC_EN, LOSC_IN, HOSC_IN;
    wire [5:0] pv; // Pins 25, 26, 27, 34, 50, 51 from bit 0
    logic [31:0] q;
    logic e;
    int mismatches = 0;
    int n_tests = 0;
    int n;
    int c;

    sopm_top #(.ONESHOT_CYC(SHOT)) dut_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .LOSC_IN(LOSC_IN), .HOSC_IN(HOSC_IN), .TMR_UNDERFLOW(TMR_UNDERFLOW), .BUZZER_WAVE_IN(BUZZER_WAVE_IN),
        .MAP_SEL(MAP_SEL), .HOSC_EN(HOSC_EN), .PORT_PIN_25(pv[0]), .PORT_PIN_26(pv[1]), .PORT_PIN_27(pv[2]),
        .PORT_PIN_34(pv[3]), .PORT_PIN_50(pv[4]), .PORT_PIN_51(pv[5]));
    sopm_osc_model #(.LP(LP * 8), .HP(HP * 8)) osc_u (.hosc_en(HOSC_EN), .losc(LOSC_IN), .hosc(HOSC_IN));

    // Core clock, 8 ns period
    initial
    begin
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    // Hang guard, well past the expected run length
    initial
    begin
        #700000;
        mismatches++;
        complete_run;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // One bus transfer; holds the request until the answer is sampled
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'h1;
        @(posedge CORE_CLK);
        while (PREADY !== 1'h1)
            @(posedge CORE_CLK);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        // Writes land at the accepted edge; give the pins one more
        repeat (2) @(posedge CORE_CLK);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0000_0000);
        chk(q, exp, "read");
    endtask

    // Cycles between two rising edges of one pin, bounded
    task automatic per(input int i, output int p);
        int k;
        int s;
        k = 0;
        s = 0;
        repeat (2)
        begin
            s = k;
            while (pv[i] !== 1'h0 && k < 30000)
            begin
                @(posedge CORE_CLK);
                k++;
            end
            while (pv[i] !== 1'h1 && k < 30000)
            begin
                @(posedge CORE_CLK);
                k++;
            end
        end
        p = k - s;
    endtask

    // One underflow pulse, then let the pin flop catch up
    task automatic uf;
        TMR_UNDERFLOW <= 1'h1;
        @(posedge CORE_CLK);
        TMR_UNDERFLOW <= 1'h0;
        repeat (3) @(posedge CORE_CLK);
    endtask

    task automatic rst(input logic m);
        RST_B <= 1'h0;
        MAP_SEL <= m;
        repeat (12) @(posedge CORE_CLK);
        RST_B <= 1'h1;
        repeat (6) @(posedge CORE_CLK);
    endtask

    task automatic t_reset;
        rd(`SOPM_CTRL_OFS, 32'h0000_0000);
        rd(`SOPM_PORT_OFS, 32'h0000_002F);
        chk(pv, 6'h2F, "reset pins");
        chk(HOSC_EN, 1'h0, "osc off");
        rd(12'h010, 32'h0000_0000);
        chk(e, 1'h1, "unmapped");
        $display("done reset");
    endtask

    task automatic t_lcd;
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0003);
        per(0, n);
        chk(n, LP * (32768 / 2048), "sync 1/32");
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0007);
        per(0, n);
        chk(n, LP * (32768 / 1024), "sync 1/16");
        per(1, n);
        chk(n, LP * (32768 / 32), "alt 1/16");
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_000B);
        per(1, n);
        chk(n, LP * (32768 / 64), "alt 1/8");
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0000);
        repeat (3) @(posedge CORE_CLK);
        chk(pv[1:0], 2'h3, "lcd idle");
        $display("done lcd");
    endtask

    task automatic t_divided_osc_out;
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0200);
        chk(HOSC_EN, 1'h1, "osc on");
        repeat (20) @(posedge CORE_CLK);
        for (c = 0; c < 8; c++)
        begin
            xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0220 | (c << 6));
            per(3, n);
            chk(n, (c < 4 ? LP : HP) << (c % 4), "divided clock");
        end
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0000);
        repeat (3) @(posedge CORE_CLK);
        chk({HOSC_EN, pv[3]}, 2'h1, "div idle");
        $display("done divided_osc_out");
    endtask

    task automatic t_tclk;
        // Pin 27 data stays at its reset one
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0010);
        repeat (2) @(posedge CORE_CLK);
        chk(pv[2], 1'h0, "tclk start");
        for (c = 1; c < 4; c++)
        begin
            uf;
            chk(pv[2], c % 2, "tclk toggle");
        end
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0000);
        repeat (2) @(posedge CORE_CLK);
        chk(pv[2], 1'h1, "tclk idle");
        $display("done tclk");
    endtask

    task automatic t_buzz;
        // Pin 50 data stays at its reset zero
        BUZZER_WAVE_IN <= 1'h1;
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0001);
        chk(pv[4], 1'h1, "buzz on");
        BUZZER_WAVE_IN <= 1'h0;
        repeat (2) @(posedge CORE_CLK);
        chk(pv[4], 1'h0, "buzz wave");
        BUZZER_WAVE_IN <= 1'h1;
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0000);
        chk(pv[4], 1'h0, "buzz off");
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0002);
        rd(`SOPM_BUZZ_OFS, 32'h0000_0002);
        chk(pv[4], 1'h1, "shot on");
        repeat (SHOT + 5) @(posedge CORE_CLK);
        chk(pv[4], 1'h0, "shot end");
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0002);
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0004);
        chk(pv[4], 1'h0, "shot stop");
        $display("done buzz");
    endtask

    task automatic t_map1;
        chk(pv[2:1], 2'h2, "map idle");
        xfer(1'h1, `SOPM_PORT_OFS, 32'h0000_000D);
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0010);
        chk(pv[2:1], 2'h1, "inv tclk");
        uf;
        chk(pv[2:1], 2'h2, "inv toggle");
        uf;
        xfer(1'h1, `SOPM_CTRL_OFS, 32'h0000_0000);
        chk(pv[2:1], 2'h2, "inv idle");
        chk(pv[5:4], 2'h2, "inv buzz idle");
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0001);
        chk(pv[5:4], 2'h1, "inv buzz");
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0000);
        chk(pv[5:4], 2'h2, "inv buzz off");
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0002);
        chk(pv[5:4], 2'h1, "inv shot");
        xfer(1'h1, `SOPM_BUZZ_OFS, 32'h0000_0004);
        chk(pv[5:4], 2'h2, "inv stop");
        rd(`SOPM_STAT_OFS, 32'h0000_006D);
        $display("done map1");
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence: first mapping, then reset into the second
    initial
    begin
        rst(1'h0);
        t_reset;
        t_lcd;
        t_divided_osc_out;
        t_tclk;
        t_buzz;
        rst(1'h1);
        t_map1;
        complete_run;
    end
endmodule // tb
